/* File: core/tpc_pkg.sv */
// Overview of operation
// - running: timer register write changes only reload value, counter takes it at reload
// - normal mode: count pin rising edge with gating pin high counts up
// - normal mode: count pin falling edge with gating pin high counts down
// - x4 mode: count pin rising while gating high, every edge counts up
// - x4 mode: count pin falling while gating high, every edge counts down
// - free-run: overflow or underflow wraps the counter, no reload
// - selectable channel alone has a normal or x4 choice bit
// - fixed-normal channel always uses normal processing
// - fixed-quadruple channel always uses x4 processing
// - without free-run, wrap reloads counter, keeps counting, raises interrupt
// - counting only while start flag is 1, halts when cleared
// - stopped: timer register write loads reload register and counter
package tpc_pkg;

  // bus geometry
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 32;
  localparam int          CNT_W        = 16;

  // register byte offsets
  localparam logic [4:0]  OFF_TIMER    = 5'h00;
  localparam logic [4:0]  OFF_CTRL     = 5'h04;
  localparam logic [4:0]  OFF_STATUS   = 5'h08;
  localparam logic [4:0]  OFF_MASK     = 5'h0C;
  localparam logic [4:0]  OFF_RELOAD   = 5'h10;

  // control fields
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_FREE    = 1;
  localparam int          CTRL_MUL4    = 2;
  localparam int          CTRL_W       = 3;

  // status and mask fields
  localparam int          ST_OVF       = 0;
  localparam int          ST_UNF       = 1;
  localparam int          ST_W         = 2;

  // reset values, counter end points and unit step
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [2:0]  RST_CTRL     = 3'h0;
  localparam logic [1:0]  RST_STATUS   = 2'h0;
  localparam logic [1:0]  RST_MASK     = 2'h0;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_MIN      = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;

  // response codes
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // pin bit positions inside the sampled pair
  localparam int          PIN_COUNT    = 0;
  localparam int          PIN_GATE     = 1;

  // channel flavours
  typedef enum logic [1:0] {
    KIND_FIXED_NORMAL = 2'h0,
    KIND_SELECTABLE   = 2'h1,
    KIND_FIXED_QUAD   = 2'h3
  } tpc_kind_e;

  // one decoded step
  typedef enum logic [1:0] {
    STEP_NONE = 2'h0,
    STEP_UP   = 2'h1,
    STEP_DOWN = 2'h2
  } tpc_step_e;

endpackage : tpc_pkg

/* File: core/tpc_sync_edge.sv */
module tpc_sync_edge #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // raw pins
  input  wire logic [WIDTH-1:0] i_pin,
  // synchronised level and the sample before it
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_prev
);

  logic [WIDTH-1:0] meta;

  // two-flop synchroniser plus one history stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta    <= '0;
      o_level <= '0;
      o_prev  <= '0;
    end else begin
      meta    <= i_pin;
      o_level <= meta;
      o_prev  <= o_level;
    end
  end

endmodule : tpc_sync_edge

/* File: core/tpc_counter.sv */
// The register addresses and the AXI4-Lite slave port were decided locally.
module tpc_counter #(
  parameter tpc_pkg::tpc_kind_e KIND = tpc_pkg::KIND_SELECTABLE,
  parameter int                 CW   = tpc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // two-phase pulse pins
  input  wire logic                   i_count_phase_pin,
  input  wire logic                   i_gating_phase_pin,
  // axi4-lite write address
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [tpc_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic [2:0]             i_awprot,
  // axi4-lite write data
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [tpc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic [3:0]             i_wstrb,
  // axi4-lite write response
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output logic [1:0]                  o_bresp,
  // axi4-lite read address
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [tpc_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic [2:0]             i_arprot,
  // axi4-lite read data
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic [tpc_pkg::DATA_W-1:0]  o_rdata,
  output logic [1:0]                  o_rresp,
  // interrupt and count value
  output logic                        o_irq,
  output logic [CW-1:0]               o_count
);

  // byte-lane merge of write data over an old value
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // quadrature step from old and new {gate, count} pair
  function automatic tpc_pkg::tpc_step_e quad_step(
    input logic [1:0] prv,
    input logic [1:0] cur
  );
    tpc_pkg::tpc_step_e s;
    s = tpc_pkg::STEP_NONE;
    case ({prv, cur})
      4'b10_11, 4'b11_01, 4'b01_00, 4'b00_10: s = tpc_pkg::STEP_UP;
      4'b11_10, 4'b01_11, 4'b00_01, 4'b10_00: s = tpc_pkg::STEP_DOWN;
      default:                                s = tpc_pkg::STEP_NONE;
    endcase
    return s;
  endfunction : quad_step

  // address match used by both channels
  function automatic logic is_mapped(input logic [4:0] a);
    return (a == tpc_pkg::OFF_TIMER)  || (a == tpc_pkg::OFF_CTRL)   ||
           (a == tpc_pkg::OFF_STATUS) || (a == tpc_pkg::OFF_MASK)   ||
           (a == tpc_pkg::OFF_RELOAD);
  endfunction : is_mapped

  // state
  logic [CW-1:0]                 count;
  logic [CW-1:0]                 reload;
  logic [tpc_pkg::CTRL_W-1:0]    ctrl;
  logic [tpc_pkg::ST_W-1:0]      status;
  logic [tpc_pkg::ST_W-1:0]      mask;
  logic [tpc_pkg::ADDR_W-1:0]    wr_addr;
  logic [tpc_pkg::DATA_W-1:0]    wr_data;
  logic [3:0]                    wr_strb;

  // pin samples
  logic [1:0]                    pin_level;
  logic [1:0]                    pin_prev;

  tpc_sync_edge #(
    .WIDTH (2)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   ({i_gating_phase_pin, i_count_phase_pin}),
    .o_level (pin_level),
    .o_prev  (pin_prev)
  );

  // mode decode
  wire running   = ctrl[tpc_pkg::CTRL_START];
  wire free_run  = ctrl[tpc_pkg::CTRL_FREE];
  wire mul4_mode = (KIND == tpc_pkg::KIND_FIXED_QUAD) ? 1'b1 :
                   (KIND == tpc_pkg::KIND_SELECTABLE)
                     ? ctrl[tpc_pkg::CTRL_MUL4] : 1'b0;

  // edge detection on registered samples
  wire cnt_lvl   = pin_level[tpc_pkg::PIN_COUNT];
  wire cnt_old   = pin_prev[tpc_pkg::PIN_COUNT];
  wire gate_lvl  = pin_level[tpc_pkg::PIN_GATE];
  wire cnt_rise  = cnt_lvl & ~cnt_old;
  wire cnt_fall  = ~cnt_lvl & cnt_old;

  // normal processing
  wire norm_up   = cnt_rise & gate_lvl;
  wire norm_dn   = cnt_fall & gate_lvl;

  // multiply-by-4 processing
  wire tpc_pkg::tpc_step_e q_step = quad_step(pin_prev, pin_level);
  wire quad_up   = (q_step == tpc_pkg::STEP_UP);
  wire quad_dn   = (q_step == tpc_pkg::STEP_DOWN);

  // counter end points and unit step at counter width
  localparam logic [CW-1:0] CNT_TOP  = CW'(tpc_pkg::CNT_MAX);
  localparam logic [CW-1:0] CNT_BOT  = CW'(tpc_pkg::CNT_MIN);
  localparam logic [CW-1:0] CNT_STEP = CW'(tpc_pkg::CNT_ONE);

  // selected step, only while started
  wire step_up   = running & (mul4_mode ? quad_up : norm_up);
  wire step_dn   = running & (mul4_mode ? quad_dn : norm_dn);
  wire overflow  = step_up & (count == CNT_TOP);
  wire underflow = step_dn & (count == CNT_BOT);
  wire wrapped   = overflow | underflow;

  // write channel handshakes
  wire aw_hs     = i_awvalid & o_awready;
  wire w_hs      = i_wvalid & o_wready;
  wire b_hs      = o_bvalid & i_bready;
  wire do_write  = ~o_awready & ~o_wready & ~o_bvalid;
  wire wr_ok     = do_write & is_mapped(wr_addr);

  // write decode
  wire wr_timer  = wr_ok & (wr_addr == tpc_pkg::OFF_TIMER);
  wire wr_ctrl   = wr_ok & (wr_addr == tpc_pkg::OFF_CTRL);
  wire wr_status = wr_ok & (wr_addr == tpc_pkg::OFF_STATUS);
  wire wr_mask   = wr_ok & (wr_addr == tpc_pkg::OFF_MASK);

  // registers widened to a bus word for merging and reading
  wire [31:0] count_word  = 32'(count);
  wire [31:0] reload_word = 32'(reload);
  wire [31:0] ctrl_word   = 32'(ctrl);
  wire [31:0] mask_word   = 32'(mask);
  wire [31:0] status_word = 32'(status);

  wire [31:0] timer_merge = merge_strb(reload_word, wr_data, wr_strb);
  wire [31:0] ctrl_merge  = merge_strb(ctrl_word, wr_data, wr_strb);
  wire [31:0] mask_merge  = merge_strb(mask_word, wr_data, wr_strb);
  wire [31:0] clr_merge   = merge_strb(32'h0, wr_data, wr_strb);
  wire [CW-1:0] timer_wval = timer_merge[CW-1:0];

  // reload register always takes the written value
  wire [CW-1:0] next_reload = wr_timer ? timer_wval : reload;

  // counter next value
  wire [CW-1:0] count_inc   = count + CNT_STEP;
  wire [CW-1:0] count_dec   = count - CNT_STEP;
  wire [CW-1:0] count_wrap  = overflow ? count_inc : count_dec;
  wire [CW-1:0] count_on_wrap =
    free_run ? count_wrap : next_reload;
  wire [CW-1:0] next_count =
    (wr_timer & ~running) ? timer_wval :
    wrapped               ? count_on_wrap :
    step_up               ? count_inc :
    step_dn               ? count_dec :
    count;

  // sticky status, set wins over write-one-clear
  wire [1:0] st_set   = {underflow, overflow};
  wire [1:0] st_clr   = wr_status ? clr_merge[tpc_pkg::ST_W-1:0] : 2'h0;
  wire [1:0] next_status = (status & ~st_clr) | st_set;

  wire [tpc_pkg::CTRL_W-1:0] ctrl_sel = ctrl_merge[tpc_pkg::CTRL_W-1:0];
  wire [tpc_pkg::CTRL_W-1:0] next_ctrl = wr_ctrl ?
    {(KIND == tpc_pkg::KIND_SELECTABLE) & ctrl_sel[tpc_pkg::CTRL_MUL4],
     ctrl_sel[tpc_pkg::CTRL_FREE:0]} : ctrl;
  wire [tpc_pkg::ST_W-1:0] next_mask =
    wr_mask ? mask_merge[tpc_pkg::ST_W-1:0] : mask;

  // read decode
  wire ar_hs = i_arvalid & o_arready;
  wire r_hs  = o_rvalid & i_rready;
  wire [31:0] rd_value =
    (i_araddr == tpc_pkg::OFF_TIMER)  ? count_word :
    (i_araddr == tpc_pkg::OFF_CTRL)   ?
      {29'h0, mul4_mode, ctrl[tpc_pkg::CTRL_FREE:0]} :
    (i_araddr == tpc_pkg::OFF_STATUS) ? status_word :
    (i_araddr == tpc_pkg::OFF_MASK)   ? mask_word :
    (i_araddr == tpc_pkg::OFF_RELOAD) ? reload_word :
    32'h0000_0000;
  wire [1:0] rd_resp = is_mapped(i_araddr) ? tpc_pkg::RESP_OKAY
                                           : tpc_pkg::RESP_SLVERR;

  // write response code for the captured address
  wire [1:0] wr_resp = is_mapped(wr_addr) ? tpc_pkg::RESP_OKAY
                                          : tpc_pkg::RESP_SLVERR;

  // counter core
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count  <= tpc_pkg::RST_COUNT;
      reload <= tpc_pkg::RST_COUNT;
      ctrl   <= tpc_pkg::RST_CTRL;
      status <= tpc_pkg::RST_STATUS;
      mask   <= tpc_pkg::RST_MASK;
    end else begin
      count  <= next_count;
      reload <= next_reload;
      ctrl   <= next_ctrl;
      status <= next_status;
      mask   <= next_mask;
    end
  end

  // registered outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq   <= 1'b0;
      o_count <= tpc_pkg::RST_COUNT;
    end else begin
      o_irq   <= |(next_status & next_mask);
      o_count <= next_count;
    end
  end

  // write address and data capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else begin
      if (aw_hs) begin
        wr_addr <= i_awaddr;
      end
      if (w_hs) begin
        wr_data <= i_wdata;
        wr_strb <= i_wstrb;
      end
    end
  end

  // write channel control
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= tpc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        o_awready <= 1'b0;
      end else if (b_hs) begin
        o_awready <= 1'b1;
      end
      if (w_hs) begin
        o_wready <= 1'b0;
      end else if (b_hs) begin
        o_wready <= 1'b1;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_resp;
      end else if (b_hs) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // read channel control
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= tpc_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= rd_value;
        o_rresp   <= rd_resp;
      end else if (r_hs) begin
        o_arready <= 1'b1;
        o_rvalid  <= 1'b0;
      end
    end
  end

endmodule : tpc_counter

/* File: test/tpc_src.sv */
module tpc_src (
  // clock
  input  wire logic i_clk,
  // two-phase pins
  output logic      o_count_pin,
  output logic      o_gate_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_count_pin = 1'h0;
    o_gate_pin  = 1'h0;
  end

  // new pin pair, then hold it for h clocks
  task automatic step(input logic g, input logic c, input int h);
    o_gate_pin  <= g;
    o_count_pin <= c;
    repeat (h) @(posedge i_clk);
  endtask : step
endmodule : tpc_src

/* File: test/tpc_assertions.sv */
module tpc_chk #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst,
  // pins
  input wire logic          i_count_phase_pin,
  input wire logic          i_gating_phase_pin,
  // bus
  input wire logic          i_awvalid,
  input wire logic          o_awready,
  input wire logic          i_wvalid,
  input wire logic          o_wready,
  input wire logic          o_bvalid,
  input wire logic          i_bready,
  input wire logic          i_arvalid,
  input wire logic          o_arready,
  input wire logic          o_rvalid,
  input wire logic          i_rready,
  input wire logic [31:0]   o_rdata,
  // outputs
  input wire logic          o_irq,
  input wire logic [CW-1:0] o_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] pp;
  logic [2:0] qc;
  wire        chg = {i_gating_phase_pin, i_count_phase_pin} != pp;
  wire        bus = i_awvalid | i_wvalid | o_bvalid;

  // cycles since the last pin change or bus write
  always_ff @(posedge i_clk) begin
    pp <= {i_gating_phase_pin, i_count_phase_pin};
    if (i_rst || chg || bus) qc <= 3'h0;
    else if (qc != 3'h7) qc <= qc + 3'h1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_cnt_quiet: assert property (qc == 3'h7 |-> $stable(o_count))
    else $error("count moved while pins and bus idle");
  a_irq_cause: assert property ($rose(o_irq) |-> qc < 3'h6)
    else $error("irq rose with no recent event");
  a_wr_block: assert property (
    i_awvalid && o_awready |=> !o_awready)
    else $error("awready high after address taken");
  a_b_latency: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  a_b_stand: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped early");
  a_rd_latency: assert property (i_arvalid && o_arready
    |=> o_rvalid && !o_arready)
    else $error("read data late");
  a_rd_stand: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  a_out_reset: assert property ($fell(i_rst)
    |-> !o_bvalid && !o_rvalid && o_count == '0)
    else $error("outputs not cleared by reset");

  c_irq: cover property ($rose(o_irq));
  c_wrap: cover property (o_count == '1);
  c_slow_b: cover property (o_bvalid && !i_bready);
endmodule : tpc_chk

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'h0;
  logic        i_rst = 1'h1;
  wire logic   i_count_phase_pin;
  wire logic   i_gating_phase_pin;
  logic        i_awvalid = 1'h0;
  logic [4:0]  i_awaddr = 5'h00;
  logic [2:0]  i_awprot = 3'h0;
  logic        i_wvalid = 1'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'hF;
  logic        i_bready = 1'h0;
  logic        i_arvalid = 1'h0;
  logic [4:0]  i_araddr = 5'h00;
  logic [2:0]  i_arprot = 3'h0;
  logic        i_rready = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]  o_bresp, o_rresp, pv;
  logic [31:0] o_rdata;
  logic [15:0] o_count, q_count, n_count, e, eq, en;
  logic [33:0] expq[$];
  logic [1:0]  nseq[7] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h0, 2'h1};
  logic [1:0]  useq[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int          errors = 0;
  int          cmp_count = 0;
  int          seed = 96;
  bit          run = 1'h0;
  bit          m4 = 1'h0;

  always #2 i_clk = ~i_clk;

  tpc_counter u_tpc_counter (.*);
  tpc_counter #(.KIND(tpc_pkg::KIND_FIXED_QUAD)) u_tpc_counter_q (
    .*, .o_awready(), .o_wready(), .o_bvalid(), .o_bresp(), .o_arready(),
    .o_rvalid(), .o_rdata(), .o_rresp(), .o_irq(), .o_count(q_count));
  tpc_counter #(.KIND(tpc_pkg::KIND_FIXED_NORMAL)) u_tpc_counter_n (
    .*, .o_awready(), .o_wready(), .o_bvalid(), .o_bresp(), .o_arready(),
    .o_rvalid(), .o_rdata(), .o_rresp(), .o_irq(), .o_count(n_count));
  tpc_src u_tpc_src (
    .i_clk       (i_clk),
    .o_count_pin (i_count_phase_pin),
    .o_gate_pin  (i_gating_phase_pin)
  );

  task automatic chk(input logic [33:0] s, input logic [33:0] x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // responses checked against the oldest note
  always @(posedge i_clk) begin
    if ((o_rvalid & i_rready) === 1'h1)
      chk({o_rresp, o_rdata}, expq.pop_front());
    if ((o_bvalid & i_bready) === 1'h1) chk({o_bresp, 32'h0}, expq.pop_front());
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    @(posedge i_clk);
    i_awvalid <= 1'h1;
    i_wvalid  <= 1'h1;
    i_awaddr  <= a;
    i_wdata   <= d;
    expq.push_back({r, 32'h0});
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
      if (o_bvalid && i_bready) i_bready <= 1'h0;
      else i_bready <= i_bready | 1'($random(seed));
    end while (!(o_bvalid && i_bready));
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] x,
                    input logic [1:0] r = 2'h0);
    @(posedge i_clk);
    i_arvalid <= 1'h1;
    i_araddr  <= a;
    expq.push_back({r, x});
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'h0;
      if (o_rvalid && i_rready) i_rready <= 1'h0;
      else i_rready <= i_rready | 1'($random(seed));
    end while (!(o_rvalid && i_rready));
  endtask : rd

  function automatic logic [1:0] ix(input logic [1:0] s);
    return s == 2'h2 ? 2'h0 : s == 2'h3 ? 2'h1 : s == 2'h1 ? 2'h2 : 2'h3;
  endfunction : ix

  // step expected from {gate, count} before and after
  function automatic logic [15:0] dlt(input bit x4, input logic [1:0] p,
                                      input logic [1:0] q);
    logic [1:0] d;
    d = ix(q) - ix(p);
    if (x4) return d == 2'h1 ? 16'h1 : d == 2'h3 ? 16'hFFFF : 16'h0;
    if (q[1] && p[0] != q[0]) return q[0] ? 16'h1 : 16'hFFFF;
    return 16'h0;
  endfunction : dlt

  task automatic mv(input logic [1:0] s);
    if (run) e = e + dlt(m4, pv, s);
    if (run) eq = eq + dlt(1'h1, pv, s);
    if (run) en = en + dlt(1'h0, pv, s);
    pv = s;
    u_tpc_src.step(s[1], s[0], 3 + ($random(seed) & 3));
  endtask : mv

  // pin change reaches the count three edges later
  task automatic sett;
    repeat (6) @(posedge i_clk);
  endtask : sett

  initial begin
    pv = 2'h0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    for (int a = 0; a < 20; a += 4) rd(5'(a), 32'h0);
    $display("reset values done");
    e = {4'h1, 12'($random(seed))};
    eq = e;
    en = e;
    wr(tpc_pkg::OFF_TIMER, {16'h0, e});
    rd(tpc_pkg::OFF_TIMER, {16'h0, e});
    rd(tpc_pkg::OFF_RELOAD, {16'h0, e});
    wr(tpc_pkg::OFF_CTRL, 32'h1);
    run = 1'h1;
    foreach (nseq[i]) mv(nseq[i]);
    sett();
    rd(tpc_pkg::OFF_TIMER, {16'h0, e});
    chk(o_count, e);
    chk(q_count, eq);
    $display("normal counting done");
    wr(tpc_pkg::OFF_CTRL, 32'h5);
    m4 = 1'h1;
    rd(tpc_pkg::OFF_CTRL, 32'h5);
    for (int i = 0; i < 12; i++) mv(i < 8 ? useq[i % 4] : useq[3 - i % 4]);
    sett();
    rd(tpc_pkg::OFF_TIMER, {16'h0, e});
    chk(q_count, eq);
    chk(n_count, en);
    chk(o_count, e);
    $display("x4 counting done");
    wr(tpc_pkg::OFF_CTRL, 32'h4);
    run = 1'h0;
    mv(2'h2);
    sett();
    rd(tpc_pkg::OFF_TIMER, {16'h0, e});
    chk(q_count, eq);
    $display("stop done");
    wr(tpc_pkg::OFF_TIMER, 32'hFFFF);
    wr(tpc_pkg::OFF_MASK, 32'h1);
    wr(tpc_pkg::OFF_CTRL, 32'h1);
    wr(tpc_pkg::OFF_TIMER, 32'h0100);
    rd(tpc_pkg::OFF_TIMER, 32'hFFFF);
    rd(tpc_pkg::OFF_RELOAD, 32'h0100);
    mv(2'h3);
    sett();
    rd(tpc_pkg::OFF_TIMER, 32'h0100);
    chk(o_irq, 1'h1);
    rd(tpc_pkg::OFF_STATUS, 32'h1);
    wr(tpc_pkg::OFF_STATUS, 32'h1);
    sett();
    chk(o_irq, 1'h0);
    $display("reload done");
    wr(tpc_pkg::OFF_CTRL, 32'h0);
    wr(tpc_pkg::OFF_TIMER, 32'h0);
    wr(tpc_pkg::OFF_CTRL, 32'h3);
    mv(2'h2);
    sett();
    rd(tpc_pkg::OFF_TIMER, 32'hFFFF);
    rd(tpc_pkg::OFF_STATUS, 32'h2);
    chk(o_irq, 1'h0);
    $display("free run done");
    wr(tpc_pkg::OFF_CTRL, 32'h0);
    i_wstrb <= 4'h2;
    wr(tpc_pkg::OFF_TIMER, 32'h0000_12AB);
    i_wstrb <= 4'hF;
    rd(tpc_pkg::OFF_TIMER, 32'h0000_1200);
    $display("byte strobe done");
    wr(5'h14, 32'h1, tpc_pkg::RESP_SLVERR);
    rd(5'h14, 32'h0, tpc_pkg::RESP_SLVERR);
    $display("unmapped done");
    repeat (2) @(posedge i_clk);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_of_test();
  end
endmodule : tb_top

bind tpc_counter tpc_chk #(.CW(CW)) u_tpc_chk (
  .i_clk              (i_clk),
  .i_rst              (i_rst),
  .i_count_phase_pin  (i_count_phase_pin),
  .i_gating_phase_pin (i_gating_phase_pin),
  .i_awvalid          (i_awvalid),
  .o_awready          (o_awready),
  .i_wvalid           (i_wvalid),
  .o_wready           (o_wready),
  .o_bvalid           (o_bvalid),
  .i_bready           (i_bready),
  .i_arvalid          (i_arvalid),
  .o_arready          (o_arready),
  .o_rvalid           (o_rvalid),
  .i_rready           (i_rready),
  .o_rdata            (o_rdata),
  .o_irq              (o_irq),
  .o_count            (o_count)
);
